// ===== rtl/port_pin_control.sv
// One eight-pin general purpose port with guarded control registers.
// Assumes a CPU-side write strobe per register and pads that take drive, enable and pull-up.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - A cleared direction bit makes the pin an output and a set bit makes it an input.
// - In output mode a cleared latch bit drives the pin low and a set bit drives it high.
// - Pull-ups are chosen per pin and act only while that pin is an input.
// - Level and hysteresis bits per pin pick Schmitt1 (00), Schmitt3 (hyst) or TTL (level).
// - One global read-source bit returns latch when clear, pin level when set, for outputs.
// - Nine redirection registers select where peripheral functions are routed.
// - The guard protects direction, pull-up, level, hysteresis and redirection registers.
// - An output-only pin can never become an input whatever software writes.
// - While guarded, writes to those registers are dropped but reads still return contents.
// - The guard is bit 2 of the access guard control register.
// - After reset the guard is off so port writes take effect until software sets it.
module port_pin_control
  import port_pin_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] write_data,
  input wire logic write_direction,
  input wire logic write_latch,
  input wire logic write_pullup,
  input wire logic write_level,
  input wire logic write_hysteresis,
  input wire logic write_analog,
  input wire logic write_converter,
  input wire logic write_guard_ctrl,
  input wire logic [8:0] write_redirect,
  input wire logic write_read_source,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  output logic [7:0] pullup_on,
  output logic [15:0] buffer_select,
  output logic [7:0] digital_enable,
  output logic [7:0] port_read,
  output logic [7:0] pin_direction_reg,
  output logic [7:0] pullup_select_reg,
  output logic [7:0] input_level_select_reg,
  output logic [7:0] input_hysteresis_select_reg,
  output logic [7:0] analog_digital_select_regs,
  output logic [7:0] converter_pin_config_reg,
  output logic [7:0] access_guard_ctrl,
  output logic read_source_select,
  output logic [71:0] peripheral_redirect_regs,
  output logic port_guard_bit
);

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  // Pins are asynchronous; a change is accepted once stages two and three agree.
  // Only the second stage reads the first, which keeps a metastable value out of the compare.
  logic [7:0] sync1;
  logic [7:0] sync2;
  logic [7:0] sync3;
  logic [7:0] pin_level;

  always_ff @(posedge clock) begin
    if (rst) begin
      sync1 <= 8'h00;
      sync2 <= 8'h00;
      sync3 <= 8'h00;
      pin_level <= 8'h00;
    end else begin
      sync1 <= pin_in;
      sync2 <= sync1;
      sync3 <= sync2;
      for (int i = 0; i < PIN_COUNT; i++) begin
        if (sync2[i] == sync3[i]) begin
          pin_level[i] <= sync3[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Guard
  // ----------------------------------------------------------------------
  logic guarded;
  assign guarded = access_guard_ctrl[GUARD_BIT_POS];

  always_ff @(posedge clock) begin
    if (rst) begin
      access_guard_ctrl <= GUARD_CTRL_RESET;
    end else if (write_guard_ctrl) begin
      access_guard_ctrl <= write_data;
    end
  end

  // The copy is its own flop so the output stays registered; it loads on the same edge as
  // the control register, so the two never disagree.
  always_ff @(posedge clock) begin
    if (rst) begin
      port_guard_bit <= GUARD_CTRL_RESET[GUARD_BIT_POS];
    end else begin
      port_guard_bit <= (write_guard_ctrl ? write_data[GUARD_BIT_POS] : guarded);
    end
  end

  // ----------------------------------------------------------------------
  // Guarded control registers
  // ----------------------------------------------------------------------
  // Reads of these registers are plain outputs and never gated by the guard.
  always_ff @(posedge clock) begin
    if (rst) begin
      pin_direction_reg <= DIR_RESET | OUTPUT_ONLY_MASK;
    end else if (write_direction && !guarded) begin
      pin_direction_reg <= write_data;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pullup_select_reg <= PULLUP_RESET;
      input_level_select_reg <= LEVEL_RESET;
      input_hysteresis_select_reg <= HYST_RESET;
      analog_digital_select_regs <= ANALOG_RESET;
      converter_pin_config_reg <= CONV_RESET;
    end else if (!guarded) begin
      if (write_pullup) begin
        pullup_select_reg <= write_data;
      end
      if (write_level) begin
        input_level_select_reg <= write_data;
      end
      if (write_hysteresis) begin
        input_hysteresis_select_reg <= write_data;
      end
      if (write_analog) begin
        analog_digital_select_regs <= write_data;
      end
      if (write_converter) begin
        converter_pin_config_reg <= write_data;
      end
    end
  end

  genvar r;
  generate
    for (r = 0; r < REDIRECT_COUNT; r++) begin : g_redirect
      always_ff @(posedge clock) begin
        if (rst) begin
          peripheral_redirect_regs[r*REDIRECT_WIDTH +: REDIRECT_WIDTH] <= REDIRECT_RESET;
        end else if (write_redirect[r] && !guarded) begin
          peripheral_redirect_regs[r*REDIRECT_WIDTH +: REDIRECT_WIDTH] <= write_data;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Unguarded latch and read source
  // ----------------------------------------------------------------------
  // The latch is left outside the guard so software can still move pins while the
  // configuration is locked.
  logic [7:0] latch;

  always_ff @(posedge clock) begin
    if (rst) begin
      latch <= LATCH_RESET;
    end else if (write_latch) begin
      latch <= write_data;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      read_source_select <= 1'b0;
    end else if (write_read_source) begin
      read_source_select <= write_data[0];
    end
  end

  // ----------------------------------------------------------------------
  // Pad control
  // ----------------------------------------------------------------------
  // Output-only pins ignore the direction bit, so they always drive.
  logic [7:0] is_output;
  assign is_output = ~pin_direction_reg | OUTPUT_ONLY_MASK;

  function automatic logic [1:0] buffer_code(input logic level, input logic hyst);
    buffer_code = {level, hyst};
  endfunction

  // Pad controls trail the registers by one cycle, traded for outputs straight from flops.
  // Digital enable is set only where both analog selects are cleared by software.
  always_ff @(posedge clock) begin
    if (rst) begin
      pin_out <= LATCH_RESET;
      // The output-only pin has no input mode to fall back on, so it drives even in reset.
      pin_oe <= ~DIR_RESET | OUTPUT_ONLY_MASK;
      pullup_on <= 8'h00;
      buffer_select <= 16'h0000;
      digital_enable <= 8'h00;
      port_read <= 8'h00;
    end else begin
      pin_out <= latch;
      pin_oe <= is_output;
      pullup_on <= pullup_select_reg & ~is_output;
      digital_enable <= ~analog_digital_select_regs & ~converter_pin_config_reg;
      for (int i = 0; i < PIN_COUNT; i++) begin
        buffer_select[2*i +: 2] <= buffer_code(input_level_select_reg[i],
                                               input_hysteresis_select_reg[i]);
        if (is_output[i] && !read_source_select) begin
          port_read[i] <= latch[i];
        end else begin
          port_read[i] <= pin_level[i];
        end
      end
    end
  end

endmodule // port_pin_control

`default_nettype wire

// ===== rtl/port_pin_pkg.sv
// Constants for the general purpose port block.
// Assumes a single system clock and a synchronous active-high reset.
package port_pin_pkg;
  localparam int PIN_COUNT = 8;
  localparam int REDIRECT_COUNT = 9;
  localparam int REDIRECT_WIDTH = 8;
  localparam int GUARD_BIT_POS = 2;
  localparam int GUARD_CTRL_WIDTH = 8;
  localparam logic [7:0] DIR_RESET = 8'hFF;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [7:0] PULLUP_RESET = 8'h00;
  localparam logic [7:0] LEVEL_RESET = 8'h00;
  localparam logic [7:0] HYST_RESET = 8'h00;
  localparam logic [7:0] ANALOG_RESET = 8'hFF;
  localparam logic [7:0] CONV_RESET = 8'h00;
  localparam logic [7:0] REDIRECT_RESET = 8'h00;
  localparam logic [7:0] GUARD_CTRL_RESET = 8'h00;
  // Pins that can only drive; a set bit marks an output-only pin.
  localparam logic [7:0] OUTPUT_ONLY_MASK = 8'h80;
  // Input buffer selection codes.
  typedef enum logic [1:0] {
    BUF_SCHMITT1 = 2'b00,
    BUF_SCHMITT3 = 2'b01,
    BUF_TTL = 2'b10,
    BUF_RESERVED = 2'b11
  } input_buffer_t;
endpackage

// ===== test/port_pin_control_tb.sv
// Self-checking bench for the port block; inputs change at the falling edge.
// Assumes the package constants and the bound monitor.
`timescale 1ns/1ps
`default_nettype none
module port_pin_control_tb
  import port_pin_pkg::*;
;
  // ------------------------------------------------------------
  // Rows hold direction, latch, pull-up, then expected oe, out and pull-up.
  // ------------------------------------------------------------
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] write_data = 8'h00, pin_in = 8'h00;
  logic [9:0] stb = 10'h000;
  logic [7:0] pin_out, pin_oe, pullup_on, digital_enable, port_read, pin_direction_reg;
  logic [15:0] buffer_select;
  logic [71:0] peripheral_redirect_regs;
  logic port_guard_bit;
  logic read_source_select;
  logic [7:0] pullup_select_reg;
  int fail_count = 0, check_count = 0, cycles = 0;
  logic [47:0] rows [4] = '{48'h00A5FF_FFA500, 48'hFF5AFF_805A7F, 48'h0F3C33_F03C03,
    48'hF0C31E_8FC310};
  always #20 clock = ~clock;
  port_pin_control uut (.clock, .rst, .write_data, .write_direction(stb[0]), .write_latch(stb[1]),
    .write_pullup(stb[2]), .write_level(stb[3]), .write_hysteresis(stb[4]), .write_analog(stb[5]),
    .write_converter(stb[6]), .write_guard_ctrl(stb[7]), .write_redirect({8'h00, stb[9]}),
    .write_read_source(stb[8]), .pin_in, .pin_out, .pin_oe, .pullup_on, .buffer_select,
    .digital_enable, .port_read, .pin_direction_reg, .pullup_select_reg,
    .input_level_select_reg(), .input_hysteresis_select_reg(), .analog_digital_select_regs(),
    .converter_pin_config_reg(), .access_guard_ctrl(), .read_source_select,
    .peripheral_redirect_regs, .port_guard_bit);
  task automatic wr(input int k, input logic [7:0] d);
    @(negedge clock);
    write_data = d;
    stb[k] = 1'b1;
    @(negedge clock);
    stb = 10'h000;
  endtask
  task automatic chk(input string n, input logic [71:0] e, input logic [71:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      give_verdict();
    end
  end
  initial begin
    repeat (6) @(negedge clock);
    rst = 1'b0;
    chk("dir_reset", 8'hFF, pin_direction_reg);
    chk("oe_reset", 8'h80, pin_oe);
    chk("guard_reset", 1'b0, port_guard_bit);
    chk("digital_reset", 8'h00, digital_enable);
    foreach (rows[i]) begin
      wr(0, rows[i][47:40]);
      wr(1, rows[i][39:32]);
      wr(2, rows[i][31:24]);
      repeat (3) @(negedge clock);
      chk("pin_oe", rows[i][23:16], pin_oe);
      chk("pin_out", rows[i][15:8], pin_out);
      chk("pullup_on", rows[i][7:0], pullup_on);
    end
    wr(3, 8'h0C);
    wr(4, 8'h0A);
    wr(5, 8'h00);
    wr(6, 8'h00);
    repeat (3) @(negedge clock);
    chk("buffer_select", 16'h00E4, buffer_select);
    chk("digital_enable", 8'hFF, digital_enable);
    // Port read goes through a synchroniser, so allow a generous settle time.
    wr(0, 8'h00);
    wr(1, 8'hA5);
    pin_in = 8'h5A;
    wr(8, 8'h00);
    repeat (8) @(negedge clock);
    chk("port_read_latch", 8'hA5, port_read);
    wr(8, 8'h01);
    repeat (8) @(negedge clock);
    chk("port_read_pin", 8'h5A, port_read);
    chk("read_source", 1'b1, read_source_select);
    wr(7, 8'hFB);
    wr(0, 8'h12);
    wr(9, 8'h5C);
    wr(7, 8'h04);
    wr(0, 8'h34);
    wr(9, 8'h77);
    wr(1, 8'h66);
    wr(2, 8'hAA);
    repeat (3) @(negedge clock);
    chk("guard_bit", 1'b1, port_guard_bit);
    chk("dir_guarded", 8'h12, pin_direction_reg);
    chk("oe_guarded", 8'hED, pin_oe);
    chk("redirect", 72'h5C, peripheral_redirect_regs);
    chk("latch_free", 8'h66, pin_out);
    chk("pullup_guarded", 8'h1E, pullup_select_reg);
    // A second reset in mid-run must drop the guard and restore input mode.
    rst = 1'b1;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    chk("dir_rerun", 8'hFF, pin_direction_reg);
    chk("guard_rerun", 1'b0, port_guard_bit);
    chk("oe_rerun", 8'h80, pin_oe);
    wr(0, 8'h3C);
    repeat (2) @(negedge clock);
    chk("dir_after_reset", 8'h3C, pin_direction_reg);
    chk("oe_after_reset", 8'hC3, pin_oe);
    give_verdict();
  end
endmodule // port_pin_control_tb
`default_nettype wire

// ===== test/port_pin_monitor.sv
// Concurrent checks on the outputs of the port block.
// Assumes it is bound to port_pin_control, one clock and a synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module port_pin_monitor
  import port_pin_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic write_direction,
  input wire logic write_latch,
  input wire logic write_pullup,
  input wire logic write_guard_ctrl,
  input wire logic port_guard_bit,
  input wire logic [7:0] write_data,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pullup_on,
  input wire logic [7:0] digital_enable,
  input wire logic [7:0] pin_direction_reg,
  input wire logic [7:0] pullup_select_reg,
  input wire logic [7:0] input_level_select_reg,
  input wire logic [7:0] input_hysteresis_select_reg,
  input wire logic [7:0] analog_digital_select_regs,
  input wire logic [7:0] converter_pin_config_reg,
  input wire logic [7:0] access_guard_ctrl,
  input wire logic [15:0] buffer_select
);
  // ------------------------------------------------------------
  // Pad outputs trail the registers by one edge, so the pad-output checks look back one cycle, and the latch check two cycles to the write.
  // ------------------------------------------------------------
  logic [15:0] exp_buf;
  always_comb begin
    exp_buf = 16'h0000;
    for (int i = 0; i < PIN_COUNT; i++) begin
      if (input_level_select_reg[i] && input_hysteresis_select_reg[i]) begin
        exp_buf[2*i+:2] = BUF_RESERVED;
      end else if (input_level_select_reg[i]) begin
        exp_buf[2*i+:2] = BUF_TTL;
      end else if (input_hysteresis_select_reg[i]) begin
        exp_buf[2*i+:2] = BUF_SCHMITT3;
      end else begin
        exp_buf[2*i+:2] = BUF_SCHMITT1;
      end
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  AST_DIR_OE: assert property (
    !$past(rst) |-> pin_oe == (~$past(pin_direction_reg) | OUTPUT_ONLY_MASK)) else $error("oe bad");
  AST_LATCH: assert property (
    write_latch ##1 !write_latch |=> pin_out == $past(write_data, 2)) else $error("latch bad");
  AST_PULLUP: assert property (!$past(rst) |-> pullup_on ==
    ($past(pullup_select_reg) & $past(pin_direction_reg) & ~OUTPUT_ONLY_MASK)) else $error("pull bad");
  AST_BUF: assert property (
    !$past(rst) |-> buffer_select == $past(exp_buf)) else $error("buffer bad");
  AST_DIGITAL: assert property (!$past(rst) |-> digital_enable ==
    ~($past(analog_digital_select_regs) | $past(converter_pin_config_reg))) else $error("dig bad");
  AST_GUARD_POS: assert property (
    port_guard_bit == access_guard_ctrl[GUARD_BIT_POS]) else $error("guard bit bad");
  AST_GUARD_HOLD: assert property (
    write_direction && port_guard_bit |=> $stable(pin_direction_reg)) else $error("guard leak");
  AST_GUARD_PULL: assert property (
    write_pullup && port_guard_bit |=> $stable(pullup_select_reg)) else $error("pull guard leak");
  AST_DIR_WRITE: assert property (write_direction && !port_guard_bit |=>
    (pin_direction_reg & ~OUTPUT_ONLY_MASK) == ($past(write_data) & ~OUTPUT_ONLY_MASK))
    else $error("dir write lost");
  AST_GUARD_WR: assert property (
    write_guard_ctrl |=> access_guard_ctrl == $past(write_data)) else $error("guard ctrl bad");
endmodule // port_pin_monitor
bind port_pin_control port_pin_monitor mon (.clock, .rst, .write_direction, .write_latch,
  .write_pullup, .write_guard_ctrl, .port_guard_bit, .write_data, .pin_out, .pin_oe, .pullup_on,
  .digital_enable,
  .pin_direction_reg, .pullup_select_reg, .input_level_select_reg, .input_hysteresis_select_reg,
  .analog_digital_select_regs, .converter_pin_config_reg, .access_guard_ctrl, .buffer_select);
`default_nettype wire
